// *** src/rse_buck_decode.sv ***
// Converter voltage code to millivolt decoder with reserved-code flag.
`timescale 1ns/1ps
`default_nettype none
module rse_buck_decode (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_code,
    output logic [11:0] o_level_mv,
    output logic o_level_bad
);
    import rse_pkg::*;

    logic [11:0] next_level_mv;
    logic next_level_bad;

    // Piecewise linear decode of the three code bands.
    always_comb begin
        next_level_bad = 1'b0;
        next_level_mv = 12'd0;
        if (i_code <= BUCK_RSV_LAST) begin
            next_level_bad = 1'b1;
        end else if (i_code < BUCK_BAND2_FIRST) begin
            next_level_mv = BUCK_BAND1_BASE_MV
                + 12'(({4'h0, i_code} - {4'h0, BUCK_BAND1_FIRST}) * BUCK_BAND1_STEP_MV);
        end else if (i_code <= BUCK_BAND2_LAST) begin
            next_level_mv = BUCK_BAND2_BASE_MV
                + 12'(({4'h0, i_code} - {4'h0, BUCK_BAND2_FIRST}) * BUCK_BAND2_STEP_MV);
        end else begin
            next_level_mv = BUCK_BAND3_BASE_MV
                + 12'(({4'h0, i_code} - {4'h0, BUCK_BAND3_FIRST}) * BUCK_BAND3_STEP_MV);
        end
    end

    // Registers the decoded level.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_level_mv <= 12'd0;
            o_level_bad <= 1'b1;
        end else begin
            o_level_mv <= next_level_mv;
            o_level_bad <= next_level_bad;
        end
    end

    a_top_code_level: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_code == 8'hff |=> o_level_mv == 12'd3360)
        else $error("Code ff must give 3360 mV.");
    a_mid_code_level: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_code == 8'h9d |=> o_level_mv == 12'd1400)
        else $error("Code 9d must give 1400 mV.");
    a_low_code_level: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_code == 8'h17 |=> o_level_mv == 12'd730 && !o_level_bad)
        else $error("Code 17 must give 730 mV.");
endmodule : rse_buck_decode
`default_nettype wire

// *** src/rse_pkg.sv ***
// Package with register offsets, field positions, reset values and voltage tables.
package rse_pkg;
    localparam logic [7:0] ADDR_BUCK_A_VOLTAGE_CODE = 8'h06;
    localparam logic [7:0] ADDR_BUCK_B_VOLTAGE_CODE = 8'h07;
    localparam logic [7:0] ADDR_LINREG_A_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_LINREG_B_CONTROL = 8'h09;
    localparam logic [7:0] ADDR_LINREG_A_VOLTAGE_CODE = 8'h0a;
    // Control register fields.
    localparam int CTL_ON_BIT = 0;
    localparam int CTL_GATING_BIT = 1;
    localparam int CTL_DISCHARGE_BIT = 2;
    localparam int CTL_USED_BITS = 3;
    localparam int LIN_CODE_BITS = 5;
    // Values after reset; unknown fields are given zero, discharge enable is one.
    localparam logic [7:0] RST_BUCK_CODE = 8'h00;
    localparam logic [7:0] RST_LINREG_CONTROL = 8'h04;
    localparam logic [7:0] RST_LINREG_CODE = 8'h00;
    // Converter code bands, voltages in millivolts.
    localparam logic [7:0] BUCK_RSV_LAST = 8'h13;
    localparam logic [7:0] BUCK_BAND1_FIRST = 8'h14;
    localparam logic [7:0] BUCK_BAND2_FIRST = 8'h18;
    localparam logic [7:0] BUCK_BAND2_LAST = 8'h9d;
    localparam logic [7:0] BUCK_BAND3_FIRST = 8'h9e;
    localparam logic [11:0] BUCK_BAND1_BASE_MV = 12'd700;
    localparam logic [11:0] BUCK_BAND1_STEP_MV = 12'd10;
    localparam logic [11:0] BUCK_BAND2_BASE_MV = 12'd735;
    localparam logic [11:0] BUCK_BAND2_STEP_MV = 12'd5;
    localparam logic [11:0] BUCK_BAND3_BASE_MV = 12'd1420;
    localparam logic [11:0] BUCK_BAND3_STEP_MV = 12'd20;
    // Linear regulator code range.
    localparam logic [4:0] LIN_CODE_LAST = 5'h19;
    localparam logic [11:0] LIN_BASE_MV = 12'd800;
    localparam logic [11:0] LIN_STEP_MV = 12'd100;

    // Register access port carrier.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rse_req_t;

    // Control output carrier of one linear regulator.
    typedef struct packed {
        logic run;
        logic discharge;
        logic [11:0] level_mv;
        logic level_bad;
    } rse_lin_out_t;
endpackage : rse_pkg

// *** src/rse_regs.sv ***
// Regulator setpoint and enable register bank with derived regulator controls.
// Overview of operation
// - Converter codes 0x00-0x13 reserved; 0x14-0x17 give 0.70-0.73 V, 10 mV steps.
// - Converter codes 0x18-0x9D give 0.735-1.4 V in 5 mV steps.
// - Converter codes 0x9E-0xFF give 1.42-3.36 V in 20 mV steps.
// - Linear code 0x00-0x19 gives 0.8-3.3 V, 100 mV; 0x1A-0x1F reserved.
// - First linear regulator runs on enable bit, or bit and pin when gated.
// - Second linear regulator uses the same enable gating with the pin.
// - Enable bit zero turns the regulator off, one turns it on unless gated with the pin low.
// - First discharge bit resets to one, applies resistor while regulator is off.
// - Second discharge bit resets to one, applies resistor while regulator is off.
`timescale 1ns/1ps
`default_nettype none
module rse_regs (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire rse_pkg::rse_req_t i_req,
    input wire logic i_en_pin,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    output logic [7:0] o_buck_a_level_code,
    output logic [7:0] o_buck_b_level_code,
    output logic [11:0] o_buck_a_mv,
    output logic o_buck_a_bad,
    output logic [11:0] o_buck_b_mv,
    output logic o_buck_b_bad,
    output rse_pkg::rse_lin_out_t o_linreg_a,
    output rse_pkg::rse_lin_out_t o_linreg_b
);
    import rse_pkg::*;

    logic [7:0] buck_a_voltage_code;
    logic [7:0] buck_b_voltage_code;
    logic [7:0] linreg_a_control;
    logic [7:0] linreg_b_control;
    logic [7:0] linreg_a_voltage_code;
    logic [7:0] next_buck_a_voltage_code;
    logic [7:0] next_buck_b_voltage_code;
    logic [7:0] next_linreg_a_control;
    logic [7:0] next_linreg_b_control;
    logic [7:0] next_linreg_a_voltage_code;
    logic [7:0] next_rdata;
    logic next_rvalid;
    rse_lin_out_t next_linreg_a;
    rse_lin_out_t next_linreg_b;

    // Enable gating: pin matters only when the gating bit is set.
    function automatic logic lin_run(input logic [7:0] ctl, input logic pin);
        lin_run = ctl[CTL_ON_BIT] && (!ctl[CTL_GATING_BIT] || pin);
    endfunction : lin_run

    // Discharge resistor connects while off and enabled by its bit.
    function automatic logic lin_dis(input logic [7:0] ctl, input logic pin);
        lin_dis = ctl[CTL_DISCHARGE_BIT] && !lin_run(ctl, pin);
    endfunction : lin_dis

    // Register writes and read data mux; all bits are stored as written.
    always_comb begin
        next_buck_a_voltage_code = buck_a_voltage_code;
        next_buck_b_voltage_code = buck_b_voltage_code;
        next_linreg_a_control = linreg_a_control;
        next_linreg_b_control = linreg_b_control;
        next_linreg_a_voltage_code = linreg_a_voltage_code;
        if (i_req.wr) begin
            unique case (i_req.addr)
                ADDR_BUCK_A_VOLTAGE_CODE: next_buck_a_voltage_code = i_req.wdata;
                ADDR_BUCK_B_VOLTAGE_CODE: next_buck_b_voltage_code = i_req.wdata;
                ADDR_LINREG_A_CONTROL: next_linreg_a_control = i_req.wdata;
                ADDR_LINREG_B_CONTROL: next_linreg_b_control = i_req.wdata;
                ADDR_LINREG_A_VOLTAGE_CODE: next_linreg_a_voltage_code = i_req.wdata;
                default: next_linreg_a_control = linreg_a_control;
            endcase
        end
        next_rvalid = i_req.rd;
        unique case (i_req.addr)
            ADDR_BUCK_A_VOLTAGE_CODE: next_rdata = buck_a_voltage_code;
            ADDR_BUCK_B_VOLTAGE_CODE: next_rdata = buck_b_voltage_code;
            ADDR_LINREG_A_CONTROL: next_rdata = linreg_a_control;
            ADDR_LINREG_B_CONTROL: next_rdata = linreg_b_control;
            ADDR_LINREG_A_VOLTAGE_CODE: next_rdata = linreg_a_voltage_code;
            default: next_rdata = 8'h00;
        endcase
        if (!i_req.rd) begin
            next_rdata = 8'h00;
        end
    end

    // Derived linear regulator controls.
    always_comb begin
        next_linreg_a.run = lin_run(linreg_a_control, i_en_pin);
        next_linreg_a.discharge = lin_dis(linreg_a_control, i_en_pin);
        next_linreg_a.level_mv = LIN_BASE_MV
            + 12'(linreg_a_voltage_code[LIN_CODE_BITS-1:0] * LIN_STEP_MV);
        next_linreg_a.level_bad =
            linreg_a_voltage_code[LIN_CODE_BITS-1:0] > LIN_CODE_LAST;
        next_linreg_b.run = lin_run(linreg_b_control, i_en_pin);
        next_linreg_b.discharge = lin_dis(linreg_b_control, i_en_pin);
        next_linreg_b.level_mv = 12'd0;
        next_linreg_b.level_bad = 1'b0;
    end

    // Registers the bank and its outputs.
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            buck_a_voltage_code <= RST_BUCK_CODE;
            buck_b_voltage_code <= RST_BUCK_CODE;
            linreg_a_control <= RST_LINREG_CONTROL;
            linreg_b_control <= RST_LINREG_CONTROL;
            linreg_a_voltage_code <= RST_LINREG_CODE;
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
            o_linreg_a <= '0;
            o_linreg_b <= '0;
        end else begin
            buck_a_voltage_code <= next_buck_a_voltage_code;
            buck_b_voltage_code <= next_buck_b_voltage_code;
            linreg_a_control <= next_linreg_a_control;
            linreg_b_control <= next_linreg_b_control;
            linreg_a_voltage_code <= next_linreg_a_voltage_code;
            o_rdata <= next_rdata;
            o_rvalid <= next_rvalid;
            o_linreg_a <= next_linreg_a;
            o_linreg_b <= next_linreg_b;
        end
    end

    assign o_buck_a_level_code = buck_a_voltage_code;
    assign o_buck_b_level_code = buck_b_voltage_code;

    // Converter code decoders.
    rse_buck_decode u_dec_a (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_code(buck_a_voltage_code),
        .o_level_mv(o_buck_a_mv),
        .o_level_bad(o_buck_a_bad)
    );
    rse_buck_decode u_dec_b (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_code(buck_b_voltage_code),
        .o_level_mv(o_buck_b_mv),
        .o_level_bad(o_buck_b_bad)
    );

    sequence s_ctl_a_write(logic [7:0] d);
        i_req.wr && i_req.addr == ADDR_LINREG_A_CONTROL && i_req.wdata == d;
    endsequence

    a_gate_pin_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        linreg_a_control[1:0] == 2'b11 && !i_en_pin |=> !o_linreg_a.run)
        else $error("Gated first regulator ran with pin low.");
    a_ungated_a: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        linreg_a_control[1:0] == 2'b01 |=> o_linreg_a.run)
        else $error("Ungated first regulator did not run.");
    a_gate_pin_b: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        linreg_b_control[1] && !i_en_pin |=> !o_linreg_b.run)
        else $error("Gated second regulator ran with pin low.");
    a_off_bit: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        s_ctl_a_write(8'h00) ##1 !i_req.wr |=> !o_linreg_a.run && !o_linreg_a.discharge)
        else $error("Regulator not off after enable cleared.");
    a_dis_a_on: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        s_ctl_a_write(8'h04) ##1 !i_req.wr |=> o_linreg_a.discharge)
        else $error("Discharge not applied while off.");
    a_dis_b_reset: assert property (@(posedge i_sys_clk)
        $fell(i_srst) |-> linreg_b_control == 8'h04)
        else $error("Second discharge bit not set after reset.");
    a_lin_level: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        linreg_a_voltage_code == 8'h19 |=> o_linreg_a.level_mv == 12'd3300)
        else $error("Code 19 must give 3300 mV.");
    a_read_back: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_req.wr && !i_req.rd && i_req.addr == ADDR_BUCK_A_VOLTAGE_CODE ##1
        i_req.rd && !i_req.wr && i_req.addr == ADDR_BUCK_A_VOLTAGE_CODE
        |=> o_rvalid && o_rdata == $past(buck_a_voltage_code))
        else $error("Converter code read back wrong.");
    a_ungated_b: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        linreg_b_control[1:0] == 2'b01 |=> o_linreg_b.run)
        else $error("Ungated second regulator did not run.");
    a_dis_b_off: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        linreg_b_control[0] == 1'b0 |=> o_linreg_b.discharge == linreg_b_control[2])
        else $error("Second discharge does not follow its bit while off.");
    a_rd_unmapped: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        i_req.rd && i_req.addr > ADDR_LINREG_A_VOLTAGE_CODE |=> o_rvalid && o_rdata == 8'h00)
        else $error("Unmapped read did not return zero.");
endmodule : rse_regs
`default_nettype wire

// *** tb/rse_regs_bench.sv ***
// Self-checking bench for the regulator setpoint and enable register bank.
`timescale 1ns/1ps
`default_nettype none
module rse_regs_bench;
    import rse_pkg::*;
    logic i_sys_clk;
    logic i_srst;
    rse_req_t i_req;
    logic i_en_pin;
    logic [7:0] o_rdata;
    logic o_rvalid;
    logic [7:0] o_buck_a_level_code;
    logic [7:0] o_buck_b_level_code;
    logic [11:0] o_buck_a_mv;
    logic o_buck_a_bad;
    logic [11:0] o_buck_b_mv;
    logic o_buck_b_bad;
    rse_lin_out_t o_linreg_a;
    rse_lin_out_t o_linreg_b;
    int bad_count;
    int n_compared;
    int seed;
    logic [7:0] exp_q[$];
    logic [7:0] c;
    logic [7:0] d;
    logic ra;
    logic [7:0] addrs[6] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b};
    logic [7:0] rstv[6] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h00, 8'h00};
    logic [7:0] codes[8] = '{8'h13, 8'h14, 8'h17, 8'h18, 8'h9d, 8'h9e, 8'hff, 8'h00};
    logic [7:0] lcodes[5] = '{8'h00, 8'h19, 8'h0c, 8'h1a, 8'h1f};

    rse_regs uut (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_req(i_req), .i_en_pin(i_en_pin),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_buck_a_level_code(o_buck_a_level_code),
        .o_buck_b_level_code(o_buck_b_level_code), .o_buck_a_mv(o_buck_a_mv),
        .o_buck_a_bad(o_buck_a_bad), .o_buck_b_mv(o_buck_b_mv), .o_buck_b_bad(o_buck_b_bad),
        .o_linreg_a(o_linreg_a), .o_linreg_b(o_linreg_b));

    // Free-running 250 MHz clock.
    initial begin
        i_sys_clk = 1'b0;
        forever #2 i_sys_clk = ~i_sys_clk;
    end

    // Counts one comparison and reports a mismatch at once.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // One write cycle; the strobe drops a full cycle before the next request.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_sys_clk);
        i_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge i_sys_clk);
        i_req.wr <= 1'b0;
    endtask : wr

    // One read cycle; the expected answer is noted for the monitor.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_sys_clk);
        i_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        exp_q.push_back(e);
        @(posedge i_sys_clk);
        i_req.rd <= 1'b0;
    endtask : rd

    // Lets derived outputs catch up, then steps off the edge.
    task automatic settle;
        repeat (3) @(posedge i_sys_clk);
        #1;
    endtask : settle

    // Expected converter millivolts from the code bands; reserved codes give zero.
    function automatic logic [11:0] buck_mv(input logic [7:0] v);
        if (v <= 8'h13) return 12'h000;
        if (v <= 8'h17) return BUCK_BAND1_BASE_MV + (12'(v) - 12'h014) * BUCK_BAND1_STEP_MV;
        if (v <= 8'h9d) return BUCK_BAND2_BASE_MV + (12'(v) - 12'h018) * BUCK_BAND2_STEP_MV;
        return BUCK_BAND3_BASE_MV + (12'(v) - 12'h09e) * BUCK_BAND3_STEP_MV;
    endfunction : buck_mv

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    // Takes the oldest expected note whenever a read answer appears.
    always @(posedge i_sys_clk) begin
        if (o_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(16'h0001, 16'h0000, "unexpected read answer");
            end else begin
                chk({8'h00, o_rdata}, {8'h00, exp_q.pop_front()}, "read data");
            end
        end
    end

    // Cuts a hang short.
    initial begin
        repeat (3000) @(posedge i_sys_clk);
        bad_count++;
        give_verdict();
    end

    // Main sequence.
    initial begin
        seed = 88;
        bad_count = 0;
        n_compared = 0;
        i_srst = 1'b1;
        i_req = '0;
        i_en_pin = 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        foreach (addrs[i]) rd(addrs[i], rstv[i]);
        settle();
        chk({o_linreg_a.discharge, o_linreg_b.discharge}, 16'h0003, "reset discharge");
        $display("Test reset values done");
        for (int i = 0; i < 16; i++) begin
            c = (i < 8) ? codes[i] : 8'($random(seed));
            d = 8'($random(seed));
            wr(8'h06, c);
            wr(8'h07, d);
            settle();
            chk(o_buck_a_mv, buck_mv(c), "converter a mv");
            chk(o_buck_b_mv, buck_mv(d), "converter b mv");
            chk({o_buck_a_bad, o_buck_b_bad}, {c <= 8'h13, d <= 8'h13}, "reserved flag");
            chk({o_buck_a_level_code, o_buck_b_level_code}, {c, d}, "converter codes");
        end
        rd(8'h06, c);
        rd(8'h07, d);
        // Write then read the same register back to back, with no idle cycle between.
        @(posedge i_sys_clk);
        i_req <= '{wr: 1'b1, rd: 1'b0, addr: 8'h06, wdata: 8'h5a};
        @(posedge i_sys_clk);
        i_req <= '{wr: 1'b0, rd: 1'b1, addr: 8'h06, wdata: 8'h00};
        exp_q.push_back(8'h5a);
        @(posedge i_sys_clk);
        i_req.rd <= 1'b0;
        $display("Test converter codes done");
        for (int k = 0; k < 16; k++) begin
            @(posedge i_sys_clk);
            i_en_pin <= k[3];
            wr(8'h08, {5'h00, k[2:0]});
            wr(8'h09, {5'h00, ~k[2], k[1:0]});
            settle();
            ra = k[0] & (~k[1] | k[3]);
            chk({o_linreg_a.run, o_linreg_a.discharge}, {ra, k[2] & ~ra}, "lin a");
            chk({o_linreg_b.run, o_linreg_b.discharge}, {ra, ~k[2] & ~ra}, "lin b");
        end
        rd(8'h08, 8'h07);
        rd(8'h09, 8'h03);
        $display("Test enable gating done");
        foreach (lcodes[i]) begin
            wr(8'h0a, lcodes[i]);
            settle();
            chk(o_linreg_a.level_bad, lcodes[i] > 8'h19, "lin reserved");
            if (lcodes[i] <= 8'h19) begin
                chk(o_linreg_a.level_mv, LIN_BASE_MV + 12'(lcodes[i]) * LIN_STEP_MV, "lin mv");
            end
        end
        rd(8'h0a, 8'h1f);
        $display("Test linear codes done");
        settle();
        give_verdict();
    end
endmodule : rse_regs_bench
`default_nettype wire
